// >>> aps_afe_model.sv
// analog front end model: supply and adapter comparator levels
`timescale 1ns/1ps
module aps_afe_model (
   // clock
   input  wire logic ref_clk,
   // stimulus from the bench
   input  wire logic supply_on,
   input  wire logic adapter_on,
   // comparator levels
   output logic      above_4v,
   output logic      above_uvlo,
   output logic      above_0v6,
   output logic      above_2v4,
   output logic      above_margin,
   output logic      above_285
);
   // all comparators low until the first edge
   initial {above_4v, above_uvlo, above_0v6, above_2v4} = 4'h0;
   initial {above_margin, above_285} = 2'h0;
   // sense divider ramps, so 0.6 V is crossed before 2.4 V
   always @(posedge ref_clk) begin
      above_4v     <= supply_on;
      above_uvlo   <= supply_on;
      above_0v6    <= supply_on & adapter_on;
      above_2v4    <= above_0v6 & adapter_on;
      above_margin <= above_2v4;
      above_285    <= above_2v4; // node decays after the adapter leaves
   end
endmodule

// >>> aps_pkg.sv
// constants shared by the adapter power path sequencer
package aps_pkg;
   // clock and time figures
   localparam int unsigned APS_CLK_HZ          = 200_000_000;
   localparam int unsigned APS_DETECT_DELAY_MS = 700;
   localparam int unsigned APS_OC_CHECK_MS     = 10;
   localparam int unsigned APS_DEGLITCH_MS     = 2;
   localparam int unsigned APS_DEAD_TIME_US    = 10;
   localparam int unsigned APS_DPM_STEP_US     = 1;
   localparam int unsigned APS_DETECT_CYCLES   =
      (APS_CLK_HZ / 1000) * APS_DETECT_DELAY_MS;
   localparam int unsigned APS_OC_CHECK_CYCLES =
      (APS_CLK_HZ / 1000) * APS_OC_CHECK_MS;
   localparam int unsigned APS_DEGLITCH_CYCLES =
      (APS_CLK_HZ / 1000) * APS_DEGLITCH_MS;
   localparam int unsigned APS_DEAD_CYCLES     =
      (APS_CLK_HZ / 1_000_000) * APS_DEAD_TIME_US;
   localparam int unsigned APS_DPM_STEP_CYCLES =
      (APS_CLK_HZ / 1_000_000) * APS_DPM_STEP_US;

   // register byte offsets
   localparam logic [7:0] APS_REG_STATUS   = 8'h00;
   localparam logic [7:0] APS_REG_ADJ      = 8'h04;
   localparam logic [7:0] APS_REG_ICHG     = 8'h08;
   localparam logic [7:0] APS_REG_VTARGET  = 8'h0C;
   localparam logic [7:0] APS_REG_CTRL     = 8'h10;
   localparam logic [7:0] APS_REG_IACT     = 8'h14;

   // reset values and the input limit setpoint step
   localparam logic [11:0] APS_ADJ_RST     = 12'h000;
   localparam logic [11:0] APS_ICHG_RST    = 12'h000;
   localparam logic        APS_TIED_RST    = 1'b1;
   localparam logic [11:0] APS_DPM_STEP    = 12'h001;

   // control field: adjust input tied to the gate drive regulator
   localparam int unsigned APS_CTRL_TIED   = 0;

   // status fields
   localparam int unsigned APS_ST_SUPPLY   = 0;
   localparam int unsigned APS_ST_FULLBIAS = 1;
   localparam int unsigned APS_ST_ADAPTER  = 2;
   localparam int unsigned APS_ST_DETECTED = 3;
   localparam int unsigned APS_ST_CHARGE   = 4;
   localparam int unsigned APS_ST_ACSW     = 5;
   localparam int unsigned APS_ST_BATSW    = 6;
   localparam int unsigned APS_ST_DPM      = 7;
   localparam int unsigned APS_ST_CELLS    = 8;

   // charge voltage arithmetic in millivolts
   localparam logic [12:0] APS_CELL_BASE_MV = 13'h0FA0;
   localparam logic [12:0] APS_CELL_DEF_MV  = 13'h1068;
   localparam int unsigned APS_ADJ_SHIFT    = 3;
   localparam logic [2:0]  APS_CELLS_2      = 3'h2;
   localparam logic [2:0]  APS_CELLS_3      = 3'h3;
   localparam logic [2:0]  APS_CELLS_4      = 3'h4;

   // synchronised comparator flag positions
   localparam int unsigned APS_NFLAGS   = 14;
   localparam int unsigned APS_F_SUPPLY = 0;
   localparam int unsigned APS_F_UVLO   = 1;
   localparam int unsigned APS_F_0V6    = 2;
   localparam int unsigned APS_F_2V4    = 3;
   localparam int unsigned APS_F_185    = 4;
   localparam int unsigned APS_F_285    = 5;
   localparam int unsigned APS_F_OV     = 6;
   localparam int unsigned APS_F_THERMAL_SHUTDOWN  = 7;
   localparam int unsigned APS_F_TS     = 8;
   localparam int unsigned APS_F_VREF   = 9;
   localparam int unsigned APS_F_CHGN   = 10;
   localparam int unsigned APS_F_CLO    = 11;
   localparam int unsigned APS_F_CHI    = 12;
   localparam int unsigned APS_F_ILIM   = 13;
   localparam logic [13:0] APS_FLAG_RST = 14'h0400;

   // system power selector states
   typedef enum logic [1:0] {
      APS_SEL_BATT, APS_SEL_BREAK_AC, APS_SEL_AC, APS_SEL_BREAK_BATT
   } aps_sel_t;
endpackage

// >>> aps_sync3.sv
// three-stage synchroniser for asynchronous comparator flags
`timescale 1ns/1ps
module aps_sync3 #(
   parameter int unsigned  W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // flags
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         // first stage feeds only the second; output moves once 2 and 3 agree
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               s1          <= RST_VAL[i];
               s2          <= RST_VAL[i];
               s3          <= RST_VAL[i];
               sync_out[i] <= RST_VAL[i];
            end else begin
               s1 <= async_in[i];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3) begin
                  sync_out[i] <= s3;
               end
            end
         end
      end
   endgenerate
endmodule

// >>> aps_top.sv
// adapter power path sequencer: bias staging, selector, charge qualify
`timescale 1ns/1ps
module aps_top
   import aps_pkg::*;
#(
   parameter int unsigned DETECT_CYCLES   = APS_DETECT_CYCLES,
   parameter int unsigned OC_CHECK_CYCLES = APS_OC_CHECK_CYCLES,
   parameter int unsigned DEGLITCH_CYCLES = APS_DEGLITCH_CYCLES
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // comparator flags from the analog front end
   input  wire logic        supply_above_4v,
   input  wire logic        supply_above_uvlo,
   input  wire logic        sense_above_0v6,
   input  wire logic        sense_above_2v4,
   input  wire logic        adapter_above_batt_185mv,
   input  wire logic        node_above_batt_285mv,
   input  wire logic        adapter_overvoltage,
   input  wire logic        thermal_shutdown,
   input  wire logic        thermistor_in_window,
   input  wire logic        ratio_reference_above_2v4,
   input  wire logic        charge_enable_n,
   input  wire logic        cell_select_low,
   input  wire logic        cell_select_high,
   input  wire logic        input_current_over_limit,
   // bias and monitor controls
   output logic             bias_partial_en,
   output logic             bias_full_en,
   output logic             reference_out_en,
   output logic             input_current_monitor_valid,
   output logic             input_current_monitor_force_low,
   output logic             gate_drive_regulator_en,
   // switch gate drives and charging
   output logic             adapter_switch_gate_on,
   output logic             battery_switch_gate_on,
   output logic             charge_enable_out,
   output logic             input_power_limit_active,
   // open-drain adapter good
   output logic             adapter_good_n_out,
   output logic             adapter_good_n_oe,
   // setpoints
   output logic [2:0]       cell_count,
   output logic [15:0]      charge_voltage_target_mv,
   output logic [11:0]      charge_current_setpoint
);
   logic [APS_NFLAGS-1:0] flags;
   logic [APS_NFLAGS-1:0] raw_flags;
   logic        supply_ok;
   logic        adapter_valid;
   logic [31:0] detect_cnt;
   logic        detect_done;
   logic [31:0] oc_cnt;
   logic        oc_done;
   logic [31:0] dgl_cnt;
   logic        chg_enabled;
   logic [31:0] dead_cnt;
   aps_sel_t    sel_state;
   logic [11:0] adj_ratio;
   logic [11:0] ichg_prog;
   logic        adj_tied;
   logic [31:0] dpm_cnt;
   logic [12:0] next_per_cell;
   logic [31:0] next_readdata;
   logic        bus_req;
   logic        qualified;

   assign raw_flags = {input_current_over_limit, cell_select_high,
      cell_select_low, charge_enable_n, ratio_reference_above_2v4,
      thermistor_in_window, thermal_shutdown, adapter_overvoltage,
      node_above_batt_285mv, adapter_above_batt_185mv, sense_above_2v4,
      sense_above_0v6, supply_above_uvlo, supply_above_4v};

   // every comparator flag crosses in before the sequencer sees it
   aps_sync3 #(
      .W       (APS_NFLAGS),
      .RST_VAL (APS_FLAG_RST)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in (raw_flags),
      .sync_out (flags)
   );

   assign supply_ok     = flags[APS_F_SUPPLY];
   assign adapter_valid = supply_ok && flags[APS_F_2V4];

   // adapter detect delay, restarts whenever the adapter drops out
   always_ff @(posedge ref_clk) begin
      if (rst || !adapter_valid) begin
         detect_cnt  <= 32'h0;
         detect_done <= 1'b0;
      end else if (detect_cnt >= DETECT_CYCLES - 1) begin
         detect_done <= 1'b1;
      end else begin
         detect_cnt <= detect_cnt + 32'h1;
      end
   end

   // overcurrent check interval runs after the detect delay
   always_ff @(posedge ref_clk) begin
      if (rst || !detect_done) begin
         oc_cnt  <= 32'h0;
         oc_done <= 1'b0;
      end else if (oc_cnt >= OC_CHECK_CYCLES - 1) begin
         oc_done <= 1'b1;
      end else begin
         oc_cnt <= oc_cnt + 32'h1;
      end
   end

   // enable assert is immediate; release is filtered with adapter present
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         chg_enabled <= 1'b0;
         dgl_cnt     <= 32'h0;
      end else if (!flags[APS_F_CHGN]) begin
         chg_enabled <= 1'b1;
         dgl_cnt     <= 32'h0;
      end else if (!flags[APS_F_2V4]) begin
         chg_enabled <= 1'b0;
         dgl_cnt     <= 32'h0;
      end else if (dgl_cnt >= DEGLITCH_CYCLES - 1) begin
         chg_enabled <= 1'b0;
      end else begin
         dgl_cnt <= dgl_cnt + 32'h1;
      end
   end

   // bias staging by supply and sense levels
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bias_partial_en                 <= 1'b0;
         bias_full_en                    <= 1'b0;
         reference_out_en                <= 1'b0;
         input_current_monitor_valid     <= 1'b0;
         input_current_monitor_force_low <= 1'b1;
         gate_drive_regulator_en         <= 1'b0;
      end else begin
         bias_partial_en  <= supply_ok;
         bias_full_en     <= supply_ok && flags[APS_F_0V6];
         reference_out_en <= supply_ok && flags[APS_F_0V6];
         input_current_monitor_valid <= supply_ok && flags[APS_F_0V6];
         // monitor held low until full bias, not when charge is disabled
         input_current_monitor_force_low <=
            !(supply_ok && flags[APS_F_0V6]);
         gate_drive_regulator_en <=
            supply_ok && flags[APS_F_0V6] && chg_enabled;
      end
   end

   // system power selector with break-before-make
   always_ff @(posedge ref_clk) begin
      if (rst || !supply_ok) begin
         sel_state <= APS_SEL_BATT;
         dead_cnt  <= 32'h0;
      end else begin
         unique case (sel_state)
            APS_SEL_BATT: begin
               dead_cnt <= 32'h0;
               if (detect_done && flags[APS_F_285]) begin
                  sel_state <= APS_SEL_BREAK_AC;
               end
            end
            APS_SEL_BREAK_AC: begin
               if (dead_cnt >= APS_DEAD_CYCLES - 1) begin
                  sel_state <= APS_SEL_AC;
                  dead_cnt  <= 32'h0;
               end else begin
                  dead_cnt <= dead_cnt + 32'h1;
               end
            end
            APS_SEL_AC: begin
               dead_cnt <= 32'h0;
               // stay on adapter until detect is lost and node collapses toward battery
               if (!detect_done && !flags[APS_F_285]) begin
                  sel_state <= APS_SEL_BREAK_BATT;
               end
            end
            APS_SEL_BREAK_BATT: begin
               if (dead_cnt >= APS_DEAD_CYCLES - 1) begin
                  sel_state <= APS_SEL_BATT;
                  dead_cnt  <= 32'h0;
               end else begin
                  dead_cnt <= dead_cnt + 32'h1;
               end
            end
         endcase
      end
   end

   // gate drives follow the selector; nothing driven without supply
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         adapter_switch_gate_on <= 1'b0;
         battery_switch_gate_on <= 1'b0;
      end else begin
         adapter_switch_gate_on <= supply_ok &&
            (sel_state == APS_SEL_AC);
         battery_switch_gate_on <= supply_ok &&
            (sel_state == APS_SEL_BATT);
      end
   end

   assign qualified = chg_enabled && flags[APS_F_UVLO] && adapter_valid
      && flags[APS_F_185] && !flags[APS_F_OV] && !flags[APS_F_THERMAL_SHUTDOWN]
      && flags[APS_F_TS] && flags[APS_F_VREF] && detect_done && oc_done;

   // charge qualification and adapter good pin
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         charge_enable_out  <= 1'b0;
         adapter_good_n_out <= 1'b1;
         adapter_good_n_oe  <= 1'b0;
      end else begin
         charge_enable_out  <= qualified;
         adapter_good_n_out <= !detect_done;
         adapter_good_n_oe  <= detect_done;
      end
   end

   // three-level cell select decode
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cell_count <= APS_CELLS_2;
      end else if (flags[APS_F_CHI]) begin
         cell_count <= APS_CELLS_4;
      end else if (flags[APS_F_CLO]) begin
         cell_count <= APS_CELLS_3;
      end else begin
         cell_count <= APS_CELLS_2;
      end
   end

   // ratio is a 12-bit fraction, so 0.512 times it is ratio over 8 mV
   always_comb begin
      if (adj_tied) begin
         next_per_cell = APS_CELL_DEF_MV;
      end else begin
         next_per_cell = APS_CELL_BASE_MV
            + 13'(adj_ratio >> APS_ADJ_SHIFT);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         charge_voltage_target_mv <= 16'h0;
      end else begin
         charge_voltage_target_mv <=
            16'(cell_count) * 16'(next_per_cell);
      end
   end

   // input limit: step the charge setpoint down, recover slowly
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         charge_current_setpoint  <= APS_ICHG_RST;
         input_power_limit_active <= 1'b0;
         dpm_cnt                  <= 32'h0;
      end else begin
         input_power_limit_active <= flags[APS_F_ILIM];
         if (dpm_cnt >= APS_DPM_STEP_CYCLES - 1) begin
            dpm_cnt <= 32'h0;
            if (flags[APS_F_ILIM]) begin
               if (charge_current_setpoint >= APS_DPM_STEP) begin
                  charge_current_setpoint <=
                     charge_current_setpoint - APS_DPM_STEP;
               end
            end else if (charge_current_setpoint < ichg_prog) begin
               charge_current_setpoint <=
                  charge_current_setpoint + APS_DPM_STEP;
            end else begin
               charge_current_setpoint <= ichg_prog;
            end
         end else begin
            dpm_cnt <= dpm_cnt + 32'h1;
         end
      end
   end

   assign bus_req = avs_read || avs_write;

   // read mux; unmapped offsets read as zero
   always_comb begin
      next_readdata = 32'h0;
      unique case (avs_address)
         APS_REG_STATUS: begin
            next_readdata[APS_ST_SUPPLY]   = supply_ok;
            next_readdata[APS_ST_FULLBIAS] = bias_full_en;
            next_readdata[APS_ST_ADAPTER]  = adapter_valid;
            next_readdata[APS_ST_DETECTED] = detect_done;
            next_readdata[APS_ST_CHARGE]   = charge_enable_out;
            next_readdata[APS_ST_ACSW]     = adapter_switch_gate_on;
            next_readdata[APS_ST_BATSW]    = battery_switch_gate_on;
            next_readdata[APS_ST_DPM]      = input_power_limit_active;
            next_readdata[APS_ST_CELLS +: 3] = cell_count;
         end
         APS_REG_ADJ:     next_readdata[11:0] = adj_ratio;
         APS_REG_ICHG:    next_readdata[11:0] = ichg_prog;
         APS_REG_VTARGET: next_readdata[15:0] = charge_voltage_target_mv;
         APS_REG_CTRL:    next_readdata[APS_CTRL_TIED] = adj_tied;
         APS_REG_IACT:    next_readdata[11:0] = charge_current_setpoint;
         default:         next_readdata = 32'h0;
      endcase
   end

   // one wait cycle per access; answer lands on the second edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end else if (bus_req && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? next_readdata : 32'h0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // writable registers; writes take effect as waitrequest is low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         adj_ratio <= APS_ADJ_RST;
         ichg_prog <= APS_ICHG_RST;
         adj_tied  <= APS_TIED_RST;
      end else if (avs_write && !avs_waitrequest) begin
         if (avs_address == APS_REG_ADJ) begin
            adj_ratio <= avs_writedata[11:0];
         end
         if (avs_address == APS_REG_ICHG) begin
            ichg_prog <= avs_writedata[11:0];
         end
         if (avs_address == APS_REG_CTRL) begin
            adj_tied <= avs_writedata[APS_CTRL_TIED];
         end
      end
   end

   // checks on the sequencing
   AST_NO_SUPPLY: assert property (@(posedge ref_clk) disable iff (rst)
      !supply_ok |=> !bias_partial_en && !charge_enable_out
         && !adapter_switch_gate_on && !battery_switch_gate_on)
      else $error("outputs active without supply");
   AST_MONITOR_LOW: assert property (@(posedge ref_clk) disable iff (rst)
      supply_ok && !flags[APS_F_0V6] |=> input_current_monitor_force_low
         && !input_current_monitor_valid && bias_partial_en)
      else $error("monitor not forced low");
   AST_FULL_BIAS: assert property (@(posedge ref_clk) disable iff (rst)
      gate_drive_regulator_en |-> bias_full_en && reference_out_en)
      else $error("regulator on without full bias");
   AST_GOOD_DELAY: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(adapter_good_n_oe) |-> $past(detect_cnt) == 32'(DETECT_CYCLES - 1))
      else $error("adapter good asserted at wrong time");
   AST_NO_ADAPTER: assert property (@(posedge ref_clk) disable iff (rst)
      supply_ok && !detect_done && sel_state == APS_SEL_BATT
         |=> !adapter_switch_gate_on)
      else $error("adapter switch on without adapter");
   AST_CHARGE_QUAL: assert property (@(posedge ref_clk) disable iff (rst)
      charge_enable_out |-> $past(oc_done && flags[APS_F_TS]
         && !flags[APS_F_OV] && !flags[APS_F_THERMAL_SHUTDOWN]))
      else $error("charge enabled while not qualified");
   AST_BREAK_BEFORE: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(adapter_switch_gate_on) |-> $past(sel_state, 2)
         == APS_SEL_BREAK_AC && $past(dead_cnt, 2)
         == 32'(APS_DEAD_CYCLES - 1))
      else $error("dead time not observed before adapter switch");
   AST_NEVER_BOTH: assert property (@(posedge ref_clk) disable iff (rst)
      !(adapter_switch_gate_on && battery_switch_gate_on))
      else $error("both switches on");
   AST_CELLS: assert property (@(posedge ref_clk) disable iff (rst)
      flags[APS_F_CLO] && !flags[APS_F_CHI] |=> cell_count == APS_CELLS_3)
      else $error("cell decode wrong");
   AST_DPM_DOWN: assert property (@(posedge ref_clk) disable iff (rst)
      flags[APS_F_ILIM] && charge_current_setpoint != 12'h0
         && dpm_cnt == 32'(APS_DPM_STEP_CYCLES - 1)
         |=> charge_current_setpoint < $past(charge_current_setpoint))
      else $error("setpoint not reduced");

   COV_TO_ADAPTER: cover property (@(posedge ref_clk) disable iff (rst)
      $rose(adapter_switch_gate_on));
   COV_TO_BATTERY: cover property (@(posedge ref_clk) disable iff (rst)
      sel_state == APS_SEL_BREAK_BATT ##1 sel_state == APS_SEL_BREAK_BATT);
   COV_CHARGE: cover property (@(posedge ref_clk) disable iff (rst)
      $rose(charge_enable_out));
endmodule

// >>> test_aps_top.sv
// self-checking bench for the adapter power path sequencer
`timescale 1ns/1ps
module test_aps_top;
   import aps_pkg::*;
   localparam int DET = 50;
   localparam int OCC = 20;
   logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        sup, ac, chi, clo, charge_enable_n, input_current_over_limit;
   logic [3:0]  flt;
   logic        supply_above_4v, supply_above_uvlo, sense_above_0v6;
   logic        sense_above_2v4, adapter_above_batt_185mv, node_above_batt_285mv;
   logic        adapter_overvoltage, thermal_shutdown, thermistor_in_window;
   logic        ratio_reference_above_2v4, cell_select_low, cell_select_high;
   logic        bias_partial_en, bias_full_en, reference_out_en;
   logic        input_current_monitor_valid, input_current_monitor_force_low;
   logic        gate_drive_regulator_en, adapter_switch_gate_on, charge_enable_out;
   logic        battery_switch_gate_on, input_power_limit_active;
   logic        adapter_good_n_out, adapter_good_n_oe;
   logic [2:0]  cell_count;
   logic [15:0] charge_voltage_target_mv;
   logic [11:0] charge_current_setpoint;
   logic [5:0]  ev;
   int          num_errors = 0;
   int          tests_run = 0;
   int          n, k;
   // fault table drives the qualification inputs
   assign adapter_overvoltage = flt[0];
   assign thermal_shutdown = flt[1];
   assign thermistor_in_window = ~flt[2];
   assign ratio_reference_above_2v4 = ~flt[3];
   assign cell_select_low = clo;
   assign cell_select_high = chi;
   assign ev = {adapter_switch_gate_on, ~adapter_switch_gate_on,
      battery_switch_gate_on, ~battery_switch_gate_on, charge_enable_out,
      adapter_good_n_oe};
   aps_top #(.DETECT_CYCLES(DET), .OC_CHECK_CYCLES(OCC), .DEGLITCH_CYCLES(10))
      u_dut (.*);
   aps_afe_model u_afe (.ref_clk(ref_clk), .supply_on(sup), .adapter_on(ac),
      .above_4v(supply_above_4v), .above_uvlo(supply_above_uvlo),
      .above_0v6(sense_above_0v6), .above_2v4(sense_above_2v4),
      .above_margin(adapter_above_batt_185mv),
      .above_285(node_above_batt_285mv));
   // free-running 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // bounded wait on one event bit; n counts edges seen
   task automatic wt(input int s, input int lim, output int c);
      for (c = 0; c < lim && ev[s] !== 1'b1; c++) @(posedge ref_clk);
      if (c == lim) begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
      if (i == 20) begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   task automatic t_off;
      chk({bias_partial_en, adapter_switch_gate_on, battery_switch_gate_on}, 0);
      chk({charge_enable_out, adapter_good_n_oe, cell_count}, 3'h2);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, APS_REG_VTARGET, 32'h1234);
      bus(1'b0, APS_REG_STATUS, 32'h0);
      chk(q, 32'h00000200);
      $display("test off done");
   endtask
   task automatic t_idle;
      sup <= 1'b1;
      repeat (12) @(posedge ref_clk);
      chk({bias_partial_en, bias_full_en, input_current_monitor_force_low}, 3'h5);
      chk({battery_switch_gate_on, adapter_switch_gate_on}, 2'h2);
      $display("test idle done");
   endtask
   task automatic t_insert;
      ac <= 1'b1;
      wt(0, DET + 40, n);
      chk({31'h0, n >= DET && n <= DET + 12}, 1);
      chk({adapter_good_n_out, charge_enable_out}, 0);
      chk({bias_full_en, reference_out_en, input_current_monitor_valid}, 3'h7);
      chk({input_current_monitor_force_low, gate_drive_regulator_en}, 1);
      wt(2, 20, n);
      wt(5, 2100, n);
      chk({31'h0, n >= 1990 && n <= 2002}, 1);
      chk({battery_switch_gate_on, adapter_switch_gate_on}, 1);
      chk(charge_enable_out, 1);
      $display("test insert done");
   endtask
   task automatic t_qualify;
      for (k = 0; k < 4; k++) begin
         flt <= 4'h1 << k;
         repeat (10) @(posedge ref_clk);
         chk(charge_enable_out, 0);
         flt <= 4'h0;
         repeat (40) @(posedge ref_clk);
      end
      charge_enable_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk(charge_enable_out, 1);
      repeat (20) @(posedge ref_clk);
      chk({charge_enable_out, gate_drive_regulator_en}, 0);
      charge_enable_n <= 1'b0;
      $display("test qualify done");
   endtask
   task automatic t_setpoint;
      for (k = 0; k < 3; k++) begin
         // k 0 floats the pin, 1 grounds it, 2 ties it to the reference
         {chi, clo} <= k[1:0];
         repeat (10) @(posedge ref_clk);
         chk(cell_count, k + 2);
         chk(charge_voltage_target_mv, (k + 2) * 4200);
      end
      bus(1'b1, APS_REG_ADJ, 32'h800);
      bus(1'b1, APS_REG_CTRL, 32'h0);
      bus(1'b0, APS_REG_VTARGET, 32'h0);
      chk(q, 32'd17024);
      bus(1'b1, APS_REG_ICHG, 32'h10);
      repeat (4000) @(posedge ref_clk);
      chk(charge_current_setpoint, 12'h010);
      input_current_over_limit <= 1'b1;
      repeat (600) @(posedge ref_clk);
      chk({input_power_limit_active, charge_current_setpoint < 12'h010}, 3);
      input_current_over_limit <= 1'b0;
      $display("test setpoint done");
   endtask
   task automatic t_remove;
      ac <= 1'b0;
      wt(4, 40, n);
      wt(3, 2100, n);
      chk({31'h0, n >= 1990 && n <= 2002}, 1);
      chk({battery_switch_gate_on, adapter_switch_gate_on}, 2'h2);
      $display("test remove done");
   endtask
   // main sequence
   initial begin
      {rst, avs_read, avs_write, sup, ac, chi, clo} = 7'h40;
      {charge_enable_n, input_current_over_limit, flt} = 6'h0;
      avs_address = 8'h0;
      avs_writedata = 32'h0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_off();
      t_idle();
      t_insert();
      t_qualify();
      t_setpoint();
      t_remove();
      tally_and_finish();
   end
endmodule
